//--- logic/sep_pkg.sv
package sep_pkg;

  // ===========================================================================
  // protection modes
  localparam logic [2:0] MODE_NONE    = 3'h0;
  localparam logic [2:0] MODE_CHECK   = 3'h1;
  localparam logic [2:0] MODE_CORRECT = 3'h2;
  localparam logic [2:0] MODE_SCRUB   = 3'h3;
  localparam logic [2:0] MODE_EVEN    = 3'h4;
  localparam logic [2:0] MODE_ODD     = 3'h5;

  // ===========================================================================
  // register map, byte addresses
  localparam logic [15:0] ADR_CH0    = 16'h8000;
  localparam logic [15:0] ADR_CH_STEP = 16'h0008;
  localparam logic [15:0] ADR_PCTRL  = 16'hA000;
  localparam logic [15:0] ADR_PSTAT  = 16'hA008;
  localparam logic [15:0] ADR_ERRADR = 16'hA00C;

  // ===========================================================================
  // field positions
  localparam int CH_MODE_LSB  = 29;
  localparam int CH_WIDTH_BIT = 0;
  localparam int PC_GLOBAL    = 0;
  localparam int PC_MEI       = 1;
  localparam int PC_SEI       = 2;
  localparam int PC_MEB       = 3;
  localparam int PC_DIAG      = 4;
  localparam int PC_DCODE_LSB = 8;
  localparam int PS_MFLAG     = 0;
  localparam int PS_SFLAG     = 1;
  localparam int PS_MODE_LSB  = 2;
  localparam int PS_WIDTH_BIT = 5;
  localparam int PS_SYN_LSB   = 8;

  // ===========================================================================
  // reset values and latency figures
  localparam logic [2:0] MODE_RESET    = 3'h0;
  localparam logic [4:0] LAT_SCRUB_MAX = 5'h16;
  localparam logic [1:0] LAT_ONE       = 2'h1;
  localparam logic [1:0] LAT_TWO       = 2'h2;
  localparam logic [1:0] LAT_THREE     = 2'h3;
  localparam logic [6:0] HAM_TOP_POS   = 7'h47;
  localparam int         NUM_CH        = 4;

endpackage : sep_pkg

//--- logic/sep_codec.sv
`timescale 1ns/100ps
module sep_codec (
  input  wire logic [63:0] data,      // double word to code or check
  input  wire logic [7:0]  cb_in,     // stored check bits
  input  wire logic        par_mode,  // byte parity instead of hamming
  input  wire logic        par_odd,   // odd parity
  output logic      [7:0]  code,      // check bits for data
  output logic      [7:0]  syndrome,  // mismatch vector
  output logic             sbe,       // correctable single-bit error
  output logic             mbe,       // uncorrectable or parity error
  output logic      [63:0] fixed      // data with single bit repaired
);

  // position of data bit idx in the codeword, skipping power-of-two slots
  function automatic logic [6:0] dpos(input int idx);
    int k;
    logic [6:0] r;
    k = -1;
    r = 7'h00;
    for (int p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        k = k + 1;
        if (k == idx) r = p[6:0];
      end
    end
    return r;
  endfunction : dpos

  logic [6:0] ham;
  logic [7:0] par;
  logic       ovr;

  always_comb begin
    ham = 7'h00;
    for (int i = 0; i < 64; i++) begin
      if (data[i]) ham = ham ^ dpos(i);
    end
    ovr = ^data ^ ^ham;
    for (int b = 0; b < 8; b++) begin
      par[b] = ^data[8*b +: 8] ^ par_odd;
    end
    code = par_mode ? par : {ovr, ham};
    if (par_mode) begin
      syndrome = par ^ cb_in;
      sbe      = 1'b0;
      mbe      = |syndrome;
    end else begin
      syndrome = {^data ^ ^cb_in, ham ^ cb_in[6:0]};
      sbe      = syndrome[7] && (syndrome[6:0] <= sep_pkg::HAM_TOP_POS);
      mbe      = (!syndrome[7] && |syndrome[6:0]) ||
                 (syndrome[7] && (syndrome[6:0] > sep_pkg::HAM_TOP_POS));
    end
    fixed = data;
    for (int i = 0; i < 64; i++) begin
      if (sbe && dpos(i) == syndrome[6:0]) fixed[i] = ~data[i];
    end
  end

endmodule : sep_codec

//--- logic/sep_unit.sv
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
module sep_unit #(
  parameter int AW = 32                   // access address width
) (
  input  wire logic          CLOCK,       // controller clock
  input  wire logic          RESETN,      // synchronous reset
  input  wire logic          WB_CYC_I,    // bus cycle
  input  wire logic          WB_STB_I,    // bus strobe
  input  wire logic          WB_WE_I,     // bus write
  input  wire logic [15:0]   WB_ADR_I,    // register byte address
  input  wire logic [3:0]    WB_SEL_I,    // byte selects
  input  wire logic [31:0]   WB_DAT_I,    // write data
  output logic      [31:0]   WB_DAT_O,    // read data
  output logic               WB_ACK_O,    // bus acknowledge
  input  wire logic          REQ_VALID,   // access request
  output logic               REQ_READY,   // request taken
  input  wire logic          REQ_WE,      // access is a write
  input  wire logic [AW-1:0] REQ_ADDR,    // byte address
  input  wire logic [7:0]    REQ_BE,      // byte enables of the double word
  input  wire logic [63:0]   REQ_WDATA,   // write data
  input  wire logic [1:0]    REQ_CH,      // decoded channel
  input  wire logic          REQ_CORE,    // master is the processor core
  input  wire logic          REQ_SADMA,   // single-address dma transfer
  output logic               RSP_VALID,   // access finished
  output logic      [63:0]   RSP_RDATA,   // read data
  output logic               RSP_BUSERR,  // bus error to the master
  output logic               NMI_PULSE,   // nonmaskable interrupt
  output logic               MULTI_IRQ,   // multi-bit error interrupt
  output logic               SINGLE_IRQ,  // single-bit error interrupt
  output logic               MEM_REQ,     // memory beat request
  output logic               MEM_WE,      // memory beat is a write
  output logic      [AW-1:0] MEM_ADDR,    // memory beat address
  output logic      [63:0]   MEM_WDATA,   // memory write data
  output logic      [7:0]    MEM_WCB,     // check bit lines out
  output logic               MEM_CB_WE,   // check bit lines written
  input  wire logic          MEM_ACK,     // memory beat done
  input  wire logic [63:0]   MEM_RDATA,   // memory read data
  input  wire logic [7:0]    MEM_RCB      // check bit lines in
);

  // the double-word address split needs at least four address bits
  if (AW < 4 || AW > 32) begin : g_aw_check
    $error("sep_unit: AW must lie in 4..32");
  end

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RD   = 6'h02,
    S_CHK  = 6'h04,
    S_WAIT = 6'h08,
    S_WR   = 6'h10,
    S_RESP = 6'h20
  } sep_state_t;

  // ===========================================================================
  // register file
  logic [2:0]    channel_protect_mode_q [sep_pkg::NUM_CH];
  logic          chan_width32_q [sep_pkg::NUM_CH];
  logic          protect_global_enable_q;
  logic          multi_err_irq_en_q;
  logic          single_err_irq_en_q;
  logic          multi_err_buserr_en_q;
  logic          diag_enable_q;
  logic [7:0]    diag_check_code_q;
  logic          multi_err_flag_q;
  logic          single_err_flag_q;
  logic [AW-1:0] err_address_log_q;
  logic [2:0]    err_mode_log_q;
  logic          err_width_log_q;
  logic [7:0]    err_syndrome_log_q;
  logic          wb_ack_q;
  logic [31:0]   wb_dat_q;
  logic          wb_wr;
  logic [31:0]   rd_mux;
  logic [1:0]    wb_ch;
  logic          wb_is_ch;

  assign wb_wr    = WB_CYC_I && WB_STB_I && WB_WE_I && wb_ack_q;
  assign wb_ch    = 2'(WB_ADR_I[4:3]);
  assign wb_is_ch = (WB_ADR_I[15:5] == sep_pkg::ADR_CH0[15:5]) && (WB_ADR_I[2:0] == 3'h0);
  // top bit of the channel mode field
  localparam int CH_MSB = sep_pkg::CH_MODE_LSB + 2;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_is_ch) begin
      rd_mux[CH_MSB:sep_pkg::CH_MODE_LSB] = channel_protect_mode_q[wb_ch];
      rd_mux[sep_pkg::CH_WIDTH_BIT]       = chan_width32_q[wb_ch];
    end else if (WB_ADR_I == sep_pkg::ADR_PCTRL) begin
      rd_mux[sep_pkg::PC_GLOBAL]               = protect_global_enable_q;
      rd_mux[sep_pkg::PC_MEI]                  = multi_err_irq_en_q;
      rd_mux[sep_pkg::PC_SEI]                  = single_err_irq_en_q;
      rd_mux[sep_pkg::PC_MEB]                  = multi_err_buserr_en_q;
      rd_mux[sep_pkg::PC_DIAG]                 = diag_enable_q;
      rd_mux[sep_pkg::PC_DCODE_LSB +: 8]       = diag_check_code_q;
    end else if (WB_ADR_I == sep_pkg::ADR_PSTAT) begin
      rd_mux[sep_pkg::PS_MFLAG]                = multi_err_flag_q;
      rd_mux[sep_pkg::PS_SFLAG]                = single_err_flag_q;
      rd_mux[sep_pkg::PS_MODE_LSB +: 3]        = err_mode_log_q;
      rd_mux[sep_pkg::PS_WIDTH_BIT]            = err_width_log_q;
      rd_mux[sep_pkg::PS_SYN_LSB +: 8]         = err_syndrome_log_q;
    end else if (WB_ADR_I == sep_pkg::ADR_ERRADR) begin
      rd_mux[AW-1:0] = err_address_log_q;
    end
  end

  // unmapped addresses answer with zero data
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= WB_CYC_I && WB_STB_I && !wb_ack_q;
      wb_dat_q <= rd_mux;
    end
  end

  assign WB_ACK_O = wb_ack_q;
  assign WB_DAT_O = wb_dat_q;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      for (int c = 0; c < sep_pkg::NUM_CH; c++) begin
        channel_protect_mode_q[c] <= sep_pkg::MODE_RESET;
        chan_width32_q[c]         <= 1'b0;
      end
    end else if (wb_wr && wb_is_ch) begin
      if (WB_SEL_I[3]) channel_protect_mode_q[wb_ch] <= WB_DAT_I[CH_MSB:sep_pkg::CH_MODE_LSB];
      if (WB_SEL_I[0]) chan_width32_q[wb_ch] <= WB_DAT_I[sep_pkg::CH_WIDTH_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      protect_global_enable_q <= 1'b0;
      multi_err_irq_en_q      <= 1'b0;
      single_err_irq_en_q     <= 1'b0;
      multi_err_buserr_en_q   <= 1'b0;
      diag_enable_q           <= 1'b0;
      diag_check_code_q       <= 8'h00;
    end else if (wb_wr && WB_ADR_I == sep_pkg::ADR_PCTRL) begin
      if (WB_SEL_I[0]) begin
        protect_global_enable_q <= WB_DAT_I[sep_pkg::PC_GLOBAL];
        multi_err_irq_en_q      <= WB_DAT_I[sep_pkg::PC_MEI];
        single_err_irq_en_q     <= WB_DAT_I[sep_pkg::PC_SEI];
        multi_err_buserr_en_q   <= WB_DAT_I[sep_pkg::PC_MEB];
        diag_enable_q           <= WB_DAT_I[sep_pkg::PC_DIAG];
      end
      if (WB_SEL_I[1]) diag_check_code_q <= WB_DAT_I[sep_pkg::PC_DCODE_LSB +: 8];
    end
  end

  // ===========================================================================
  // access sequencer
  sep_state_t    state_q;
  logic          we_q;
  logic          core_q;
  logic          sadma_q;
  logic          partial_q;
  logic [AW-1:0] addr_q;
  logic [7:0]    be_q;
  logic [63:0]   wdata_q;
  logic [2:0]    mode_q;
  logic          w32_q;
  logic          beat_q;
  logic [63:0]   rd_q;
  logic [7:0]    rcb_q;
  logic [63:0]   wr_q;
  logic [1:0]    wait_q;
  logic          scrub_q;
  logic          mem_req_q;
  logic          mem_we_q;
  logic [63:0]   mem_wdata_q;
  logic [7:0]    mem_wcb_q;
  logic          mem_cb_we_q;
  logic          rsp_q;
  logic [63:0]   rsp_data_q;
  logic          buserr_q;
  logic          nmi_q;

  logic          is_ecc;
  logic          is_par;
  logic          chk_en;
  logic [7:0]    chk_syn;
  logic          chk_sbe;
  logic          chk_mbe;
  logic [63:0]   chk_fixed;
  logic [7:0]    gen_code;
  logic [7:0]    wr_code;
  logic          ev_sbe;
  logic          ev_mbe;
  logic [1:0]    lat;
  logic [63:0]   merged;
  logic          last_beat;

  assign is_ecc    = mode_q == sep_pkg::MODE_CHECK || mode_q == sep_pkg::MODE_CORRECT ||
                     mode_q == sep_pkg::MODE_SCRUB;
  assign is_par    = mode_q == sep_pkg::MODE_EVEN || mode_q == sep_pkg::MODE_ODD;
  assign chk_en    = protect_global_enable_q && (is_ecc || is_par);
  assign ev_mbe    = chk_en && chk_mbe;
  assign ev_sbe    = chk_en && chk_sbe;
  assign last_beat = !w32_q || beat_q;

  sep_codec u_check (
    .data     (rd_q),
    .cb_in    (rcb_q),
    .par_mode (is_par),
    .par_odd  (mode_q == sep_pkg::MODE_ODD),
    .code     (),
    .syndrome (chk_syn),
    .sbe      (chk_sbe),
    .mbe      (chk_mbe),
    .fixed    (chk_fixed)
  );

  sep_codec u_gen (
    .data     (wr_q),
    .cb_in    (8'h00),
    .par_mode (is_par),
    .par_odd  (mode_q == sep_pkg::MODE_ODD),
    .code     (gen_code),
    .syndrome (),
    .sbe      (),
    .mbe      (),
    .fixed    ()
  );

  // code stored on writes
  always_comb begin
    wr_code = gen_code;
    if (is_ecc && diag_enable_q) wr_code = diag_check_code_q;
  end

  // merge new bytes into the checked double word
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      merged[8*b +: 8] = be_q[b] ? wdata_q[8*b +: 8] : chk_fixed[8*b +: 8];
    end
  end

  // added read latency beyond the base check cycle
  always_comb begin
    lat = 2'h0;
    case (mode_q)
      sep_pkg::MODE_CHECK:   lat = multi_err_buserr_en_q ?
                                   ((ev_sbe || ev_mbe) ? sep_pkg::LAT_TWO : sep_pkg::LAT_ONE)
                                   : 2'h0;
      sep_pkg::MODE_CORRECT: lat = (ev_sbe || ev_mbe) ? sep_pkg::LAT_TWO : sep_pkg::LAT_ONE;
      sep_pkg::MODE_SCRUB:   lat = !ev_mbe ? sep_pkg::LAT_ONE :
                                   (multi_err_buserr_en_q ? sep_pkg::LAT_TWO
                                                          : sep_pkg::LAT_THREE);
      sep_pkg::MODE_EVEN,
      sep_pkg::MODE_ODD:     lat = multi_err_buserr_en_q ? sep_pkg::LAT_ONE : 2'h0;
      default:               lat = 2'h0;
    endcase
  end

  assign REQ_READY = state_q == S_IDLE;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_q     <= S_IDLE;
      we_q        <= 1'b0;
      core_q      <= 1'b0;
      sadma_q     <= 1'b0;
      partial_q   <= 1'b0;
      addr_q      <= '0;
      be_q        <= 8'h00;
      wdata_q     <= 64'h0;
      mode_q      <= sep_pkg::MODE_RESET;
      w32_q       <= 1'b0;
      beat_q      <= 1'b0;
      rd_q        <= 64'h0;
      rcb_q       <= 8'h00;
      wr_q        <= 64'h0;
      wait_q      <= 2'h0;
      scrub_q     <= 1'b0;
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_wdata_q <= 64'h0;
      mem_wcb_q   <= 8'h00;
      mem_cb_we_q <= 1'b0;
      rsp_q       <= 1'b0;
      rsp_data_q  <= 64'h0;
      buserr_q    <= 1'b0;
      nmi_q       <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      nmi_q <= 1'b0;
      case (state_q)
        S_IDLE: if (REQ_VALID) begin
          we_q      <= REQ_WE;
          core_q    <= REQ_CORE;
          sadma_q   <= REQ_SADMA;
          partial_q <= REQ_WE && REQ_BE != 8'hFF;
          addr_q    <= REQ_ADDR;
          be_q      <= REQ_BE;
          wdata_q   <= REQ_WDATA;
          wr_q      <= REQ_WDATA;
          mode_q    <= channel_protect_mode_q[REQ_CH];
          w32_q     <= chan_width32_q[REQ_CH];
          beat_q    <= 1'b0;
          scrub_q   <= 1'b0;
          buserr_q  <= 1'b0;
          state_q   <= (REQ_WE && REQ_BE == 8'hFF) ? S_WR : S_RD;
        end
        S_RD: begin
          if (!mem_req_q) begin
            mem_req_q <= 1'b1;
            mem_we_q  <= 1'b0;
          end else if (MEM_ACK) begin
            if (!w32_q) begin
              rd_q  <= MEM_RDATA;
              rcb_q <= MEM_RCB;
            end else if (!beat_q) begin
              rd_q[31:0] <= MEM_RDATA[31:0];
              rcb_q[3:0] <= MEM_RCB[3:0];
            end else begin
              rd_q[63:32] <= MEM_RDATA[31:0];
              rcb_q[7:4]  <= MEM_RCB[3:0];
            end
            beat_q <= !last_beat;
            if (last_beat) begin
              mem_req_q <= 1'b0;
              state_q   <= S_CHK;
            end
          end
        end
        S_CHK: begin
          buserr_q <= multi_err_buserr_en_q && ev_mbe && (!core_q || !partial_q);
          nmi_q    <= multi_err_buserr_en_q && ev_mbe && core_q && partial_q;
          if (chk_en && (mode_q == sep_pkg::MODE_CORRECT || mode_q == sep_pkg::MODE_SCRUB)) begin
            rsp_data_q <= chk_fixed;
          end else begin
            rsp_data_q <= rd_q;
          end
          if (we_q) begin
            wr_q    <= merged;
            state_q <= (is_ecc && ev_mbe) ? S_RESP : S_WR;
          end else begin
            wr_q    <= chk_fixed;
            scrub_q <= mode_q == sep_pkg::MODE_SCRUB && ev_sbe;
            wait_q  <= lat;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
          else state_q <= scrub_q ? S_WR : S_RESP;
        end
        S_WR: begin
          if (!mem_req_q || MEM_ACK) begin
            mem_req_q   <= !(mem_req_q && last_beat);
            mem_we_q    <= 1'b1;
            mem_cb_we_q <= !sadma_q && mode_q != sep_pkg::MODE_NONE;
            if (!w32_q) begin
              mem_wdata_q <= wr_q;
              mem_wcb_q   <= wr_code;
            end else if (!mem_req_q) begin
              mem_wdata_q <= {32'h0, wr_q[31:0]};
              mem_wcb_q   <= {4'h0, wr_code[3:0]};
            end else begin
              mem_wdata_q <= {32'h0, wr_q[63:32]};
              mem_wcb_q   <= {4'h0, wr_code[7:4]};
            end
            if (mem_req_q) beat_q <= !last_beat;
            if (mem_req_q && last_beat) state_q <= S_RESP;
          end
        end
        S_RESP: begin
          rsp_q   <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // the write path presents the upper word on its second beat
  always_comb begin
    MEM_ADDR = {addr_q[AW-1:3], 3'h0};
    if (w32_q) MEM_ADDR[2] = beat_q;
  end

  assign MEM_REQ    = mem_req_q;
  assign MEM_WE     = mem_we_q;
  assign MEM_WDATA  = mem_wdata_q;
  assign MEM_WCB    = mem_wcb_q;
  assign MEM_CB_WE  = mem_cb_we_q;
  assign RSP_VALID  = rsp_q;
  assign RSP_RDATA  = rsp_data_q;
  assign RSP_BUSERR = buserr_q;
  assign NMI_PULSE  = nmi_q;

  // ===========================================================================
  // error flags and log; a hardware set beats a software clear
  logic chk_cyc;
  logic clr_m;
  logic clr_s;

  assign chk_cyc = state_q == S_CHK;
  assign clr_m   = wb_wr && WB_ADR_I == sep_pkg::ADR_PSTAT && WB_SEL_I[0] &&
                   WB_DAT_I[sep_pkg::PS_MFLAG];
  assign clr_s   = wb_wr && WB_ADR_I == sep_pkg::ADR_PSTAT && WB_SEL_I[0] &&
                   WB_DAT_I[sep_pkg::PS_SFLAG];

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      multi_err_flag_q  <= 1'b0;
      single_err_flag_q <= 1'b0;
    end else begin
      if (chk_cyc && ev_mbe && multi_err_irq_en_q) multi_err_flag_q <= 1'b1;
      else if (clr_m) multi_err_flag_q <= 1'b0;
      if (chk_cyc && ev_mbe) single_err_flag_q <= 1'b0;
      else if (chk_cyc && ev_sbe && single_err_irq_en_q && !multi_err_flag_q)
        single_err_flag_q <= 1'b1;
      else if (clr_s) single_err_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      err_address_log_q  <= '0;
      err_mode_log_q     <= 3'h0;
      err_width_log_q    <= 1'b0;
      err_syndrome_log_q <= 8'h00;
    end else if (chk_cyc && (ev_mbe || (ev_sbe && !multi_err_flag_q))) begin
      err_address_log_q  <= addr_q;
      err_mode_log_q     <= mode_q;
      err_width_log_q    <= w32_q;
      err_syndrome_log_q <= chk_syn;
    end
  end

  assign MULTI_IRQ  = multi_err_flag_q;
  assign SINGLE_IRQ = single_err_flag_q;

endmodule : sep_unit

//--- bench/sep_unit_properties.sv
`timescale 1ns/100ps
module sep_unit_properties (
  input wire logic CLOCK,      // clock
  input wire logic RESETN,     // reset
  input wire logic WB_CYC_I,   // cycle
  input wire logic WB_STB_I,   // strobe
  input wire logic WB_ACK_O,   // ack
  input wire logic REQ_VALID,  // request
  input wire logic REQ_READY,  // idle
  input wire logic REQ_SADMA,  // sadma
  input wire logic RSP_VALID,  // done
  input wire logic MULTI_IRQ,  // multi flag
  input wire logic SINGLE_IRQ, // single flag
  input wire logic MEM_REQ,    // beat
  input wire logic MEM_WE,     // beat write
  input wire logic MEM_CB_WE,  // check write
  input wire logic MEM_ACK     // beat done
);
  // ==========================================================================
  // properties
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_wb; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_take; REQ_VALID && REQ_READY; endsequence
  property p_wb_ack; s_wb |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("register ack wrong");
  property p_lat; s_take |-> ##[2:80] RSP_VALID; endproperty
  a_lat: assert property (p_lat) else $error("access too slow");
  property p_done; RSP_VALID |-> REQ_READY ##1 !RSP_VALID; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_busy; s_take |=> !REQ_READY; endproperty
  a_busy: assert property (p_busy) else $error("second access taken");
  property p_mem_hold; MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_WE); endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("beat dropped");
  property p_sadma; REQ_SADMA && MEM_REQ && MEM_WE |-> !MEM_CB_WE; endproperty
  a_sadma: assert property (p_sadma) else $error("sadma wrote check bits");
  property p_multi_clr; $rose(MULTI_IRQ) |-> !SINGLE_IRQ; endproperty
  a_multi_clr: assert property (p_multi_clr) else $error("single flag kept");
  property p_single_blk; $rose(SINGLE_IRQ) |-> !$past(MULTI_IRQ); endproperty
  a_single_blk: assert property (p_single_blk) else $error("single flag set");
endmodule : sep_unit_properties

//--- bench/sep_mem_model.sv
`timescale 1ns/100ps
module sep_mem_model (
  input  wire logic        CLOCK,     // clock
  input  wire logic [1:0]  LAG,       // waits before ack
  input  wire logic        MEM_REQ,   // beat
  input  wire logic        MEM_WE,    // write
  input  wire logic [31:0] MEM_ADDR,  // address
  input  wire logic [63:0] MEM_WDATA, // data in
  input  wire logic [7:0]  MEM_WCB,   // check in
  input  wire logic        MEM_CB_WE, // check write
  output logic             MEM_ACK,   // done
  output logic      [63:0] MEM_RDATA, // data out
  output logic      [7:0]  MEM_RCB    // check out
);
  // ==========================================================================
  // storage, one entry per beat address
  bit   [63:0] mem [128];
  bit   [7:0]  cbs [128];
  logic [1:0]  cnt = 2'h0;
  initial {MEM_ACK, MEM_RDATA, MEM_RCB} = '0;
  always @(posedge CLOCK) begin
    MEM_ACK <= 1'b0;
    // outside an ack the lanes never hold the last value
    MEM_RDATA <= ~MEM_RDATA;
    MEM_RCB <= ~MEM_RCB;
    if (MEM_REQ && !MEM_ACK && cnt != LAG) begin
      cnt <= cnt + 2'h1;
    end else if (MEM_REQ && !MEM_ACK) begin
      cnt <= 2'h0;
      MEM_ACK <= 1'b1;
      MEM_RDATA <= mem[MEM_ADDR[8:2]];
      MEM_RCB <= cbs[MEM_ADDR[8:2]];
      if (MEM_WE) mem[MEM_ADDR[8:2]] <= MEM_WDATA;
      if (MEM_WE && MEM_CB_WE) cbs[MEM_ADDR[8:2]] <= MEM_WCB;
    end
  end
endmodule : sep_mem_model

//--- bench/sdram_ecc_parity_unit_tb_top.sv
`timescale 1ns/100ps
module sdram_ecc_parity_unit_tb_top;
  typedef struct packed {logic [2:0] m; logic [1:0] f; logic c; logic [1:0] fl;
    logic s2;} sep_row_t;
  logic CLOCK, RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, REQ_VALID, REQ_READY, REQ_WE;
  logic REQ_CORE, REQ_SADMA, RSP_VALID, RSP_BUSERR, NMI_PULSE, MULTI_IRQ, SINGLE_IRQ, MEM_REQ;
  logic MEM_WE, MEM_CB_WE, MEM_ACK;
  logic [1:0] REQ_CH, lag;
  logic [3:0] WB_SEL_I;
  logic [7:0] REQ_BE, MEM_WCB, MEM_RCB;
  logic [15:0] WB_ADR_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, REQ_ADDR, MEM_ADDR, rd;
  logic [63:0] REQ_WDATA, RSP_RDATA, MEM_WDATA, MEM_RDATA;
  int bad_count, checked, cyc, base, nmi_count;
  localparam logic [63:0] DW = 64'h0123456789ABCDEF;
  // mode, flipped bits, corrected, flags after read, single flag after re-read
  sep_row_t rows [8] = '{'{3'h0,2'h1,1'h0,2'h0,1'h0}, '{3'h1,2'h1,1'h0,2'h1,1'h1},
    '{3'h2,2'h1,1'h1,2'h1,1'h1}, '{3'h2,2'h3,1'h0,2'h2,1'h0}, '{3'h3,2'h1,1'h1,2'h2,1'h0},
    '{3'h3,2'h3,1'h0,2'h2,1'h0}, '{3'h4,2'h1,1'h0,2'h2,1'h0}, '{3'h5,2'h1,1'h0,2'h2,1'h0}};
  sep_unit u_dut (.*);
  sep_mem_model u_mem (.LAG(lag), .*);
  always @(posedge CLOCK) begin
    if (NMI_PULSE === 1'b1) nmi_count++;
  end
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (6000) @(posedge CLOCK);
    bad_count++;
    end_of_test();
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'h3, we, a, d};
    do @(posedge CLOCK); while (WB_ACK_O !== 1'b1);
    rd = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
  endtask : wb
  task automatic acc(input logic we, input logic [7:0] be, input logic [63:0] d, input logic sa);
    @(posedge CLOCK);
    {REQ_VALID, REQ_WE, REQ_BE, REQ_WDATA, REQ_SADMA} <= {1'b1, we, be, d, sa};
    do @(posedge CLOCK); while (REQ_READY !== 1'b1);
    REQ_VALID <= 1'b0;
    cyc = 0;
    do begin
      @(posedge CLOCK);
      cyc++;
    end while (RSP_VALID !== 1'b1);
  endtask : acc
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    {RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, REQ_VALID, REQ_WE, REQ_CORE, REQ_SADMA} = 8'h0;
    {WB_ADR_I, WB_DAT_I, REQ_BE, REQ_WDATA, REQ_CH, lag} = '0;
    REQ_ADDR = 32'h100;
    WB_SEL_I = 4'hF;
    repeat (8) @(posedge CLOCK);
    RESETN <= 1'b1;
    wb(1'b0, sep_pkg::ADR_CH0, 32'h0);
    chk(rd[31:29], sep_pkg::MODE_RESET);
    wb(1'b1, sep_pkg::ADR_PCTRL, 32'h7);
    foreach (rows[i]) begin
      wb(1'b1, sep_pkg::ADR_CH0, {rows[i].m, 29'h0});
      lag <= i[1:0];
      acc(1'b1, 8'hFF, DW, 1'b0);
      u_mem.mem[64] ^= 64'(rows[i].f);
      acc(1'b0, 8'hFF, 64'h0, 1'b0);
      chk(RSP_RDATA, DW ^ (rows[i].c ? 64'h0 : 64'(rows[i].f)));
      chk({MULTI_IRQ, SINGLE_IRQ}, rows[i].fl);
      wb(1'b1, sep_pkg::ADR_PSTAT, 32'h3);
      acc(1'b0, 8'hFF, 64'h0, 1'b0);
      chk(SINGLE_IRQ, rows[i].s2);
    end
    // narrow write over a single-bit error while the multi flag stands
    wb(1'b1, sep_pkg::ADR_CH0, {sep_pkg::MODE_CORRECT, 29'h0});
    acc(1'b1, 8'hFF, DW, 1'b0);
    u_mem.mem[64] ^= 64'h8000000000000000;
    acc(1'b1, 8'h01, 64'hEE, 1'b0);
    chk(SINGLE_IRQ, 1'b0);
    acc(1'b0, 8'hFF, 64'h0, 1'b0);
    chk(RSP_RDATA, {DW[63:8], 8'hEE});
    wb(1'b1, sep_pkg::ADR_PCTRL, 32'hA517);
    acc(1'b1, 8'hFF, DW, 1'b0);
    chk(u_mem.cbs[64], 8'hA5);
    wb(1'b1, sep_pkg::ADR_PCTRL, 32'h7);
    acc(1'b1, 8'hFF, ~DW, 1'b1);
    chk(u_mem.cbs[64], 8'hA5);
    wb(1'b1, sep_pkg::ADR_PSTAT, 32'h3);
    wb(1'b1, sep_pkg::ADR_PCTRL, 32'h6);
    acc(1'b0, 8'hFF, 64'h0, 1'b0);
    chk({MULTI_IRQ, SINGLE_IRQ}, 2'h0);
    // bus errors, latency, log fields and nmi in check-only mode
    wb(1'b1, sep_pkg::ADR_PCTRL, 32'hF);
    wb(1'b1, sep_pkg::ADR_CH0, {sep_pkg::MODE_CHECK, 29'h0});
    acc(1'b1, 8'hFF, DW, 1'b0);
    acc(1'b0, 8'hFF, 64'h0, 1'b0);
    base = cyc;
    u_mem.mem[64] ^= 64'h3;
    acc(1'b0, 8'hFF, 64'h0, 1'b0);
    chk(cyc, base + 1);
    chk(RSP_BUSERR, 1'b1);
    wb(1'b0, sep_pkg::ADR_PSTAT, 32'h0);
    chk(rd[15:2], {8'h06, 3'h0, sep_pkg::MODE_CHECK});
    wb(1'b0, sep_pkg::ADR_ERRADR, 32'h0);
    chk(rd, REQ_ADDR);
    REQ_CORE <= 1'b1;
    acc(1'b1, 8'h01, 64'h0, 1'b0);
    chk(nmi_count, 1);
    chk(RSP_BUSERR, 1'b0);
    chk(u_mem.mem[64], DW ^ 64'h3);
    wb(1'b1, sep_pkg::ADR_CH0, 32'h0);
    acc(1'b0, 8'hFF, 64'h0, 1'b0);
    chk(cyc + 1, base);
    // a 32-bit wide channel carries the code nibbles with the data words
    wb(1'b1, sep_pkg::ADR_CH0 + sep_pkg::ADR_CH_STEP, 32'h2000_0001);
    REQ_CH <= 2'h1;
    acc(1'b1, 8'hFF, DW, 1'b0);
    chk(u_mem.mem[65], {32'h0, DW[63:32]});
    acc(1'b0, 8'hFF, 64'h0, 1'b0);
    chk(RSP_RDATA, DW);
    chk(RSP_BUSERR, 1'b0);
    // reset in mid-run returns registers and flags to their reset values
    RESETN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RESETN <= 1'b1;
    wb(1'b0, sep_pkg::ADR_CH0 + sep_pkg::ADR_CH_STEP, 32'h0);
    chk({rd, MULTI_IRQ, SINGLE_IRQ}, 34'h0);
    end_of_test();
  end
endmodule : sdram_ecc_parity_unit_tb_top
bind sep_unit sep_unit_properties u_props (.*);
